// file: shared/adcrc_pkg.sv
package adcrc_pkg;
    // ==========================================================
    // register map (byte addresses, one aligned word each)
    localparam logic [7:0] ADCRC_CTRL_OFS = 8'h00;   // converter_control_reg
    localparam logic [7:0] ADCRC_SC_OFS = 8'h04;     // conv_status_control_reg
    localparam logic [7:0] ADCRC_RH_OFS = 8'h08;     // result_high_reg
    localparam logic [7:0] ADCRC_RL_OFS = 8'h0c;     // result_low_reg
    localparam logic [7:0] ADCRC_PE_OFS = 8'h10;     // input_pin_enable_reg
    // ==========================================================
    // field positions
    localparam int ADCRC_PU_BIT = 7;     // converter_power_up in control reg
    localparam int ADCRC_IE_BIT = 6;     // complete_irq_enable in status/control
    localparam int ADCRC_CCF_BIT = 7;    // conversion_done_flag in status/control
    localparam int ADCRC_CH_LSB = 0;     // channel select in status/control
    // ==========================================================
    // reset values
    localparam logic [7:0] ADCRC_CTRL_RST = 8'h00;
    localparam logic [7:0] ADCRC_SC_RST = 8'h00;
    localparam logic [7:0] ADCRC_PE_RST = 8'h00;
    localparam logic [9:0] ADCRC_SAR_RST = 10'h000;
    // ==========================================================
    // timing: conversion length in bus cycles
    localparam int ADCRC_CONV_CYCLES = 28;
    localparam logic [1:0] ADCRC_RESP_OKAY = 2'b00;
    localparam logic [1:0] ADCRC_RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        ADCRC_IDLE = 2'b00,
        ADCRC_CONV = 2'b01,
        ADCRC_DONE = 2'b10
    } adcrc_state_t;

    typedef struct packed {
        logic [9:0] result;
        logic done;
    } adcrc_sar_t;
endpackage : adcrc_pkg

// file: core/adcrc_top.sv
`timescale 1ns/1ps
module adcrc_top #(
    // conversion length in clock cycles, the counter holds up to 63
    parameter int CONV_CYCLES = adcrc_pkg::ADCRC_CONV_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // register bus, write side
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // register bus, read side
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // analog side
    input wire logic [9:0] sar_sample,
    // converter side outputs
    output logic converter_power_up,
    output logic conv_busy,
    output logic [2:0] channel_sel,
    output logic [7:0] pin_enable,
    output logic irq
);
    import adcrc_pkg::*;

    // ==========================================================
    // write channel capture
    // address and data may arrive in either order; each ready drops the cycle
    // after its handshake and stays low until the write has been acted on, so
    // a second write can never overwrite a held one
    logic aw_held_q;
    logic w_held_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_fire;
    // software registers
    logic [7:0] ctrl_q;
    logic [7:0] sc_q;
    logic [7:0] pe_q;
    logic ccf_q;
    // sequencer state
    adcrc_state_t state_q;
    logic [5:0] cnt_q;
    logic [9:0] sar_q;
    logic [9:0] result_q;
    // read channel
    logic rd_fire;
    logic [7:0] araddr_q;
    logic ar_held_q;

    // address decode on word boundaries; the two low address bits are ignored
    // so byte offsets within a word reach the same register
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction : hit

    // a write is acted on once both halves are held and the previous response
    // has been taken
    assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

    // address and data accepted independently, held until the pair completes
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // write response, unmapped address answered with slverr
    // the response is held until the master takes it, blocking the next write
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ADCRC_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (hit(awaddr_q, ADCRC_CTRL_OFS) || hit(awaddr_q, ADCRC_SC_OFS) ||
                            hit(awaddr_q, ADCRC_PE_OFS)) ? ADCRC_RESP_OKAY : ADCRC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    logic wr_ctrl;
    logic wr_sc;
    logic wr_pe;
    // one strobe per register, each only when byte lane 0 is written
    assign wr_ctrl = wr_fire && hit(awaddr_q, ADCRC_CTRL_OFS) && wstrb_q[0];
    assign wr_sc = wr_fire && hit(awaddr_q, ADCRC_SC_OFS) && wstrb_q[0];
    assign wr_pe = wr_fire && hit(awaddr_q, ADCRC_PE_OFS) && wstrb_q[0];

    // ==========================================================
    // software registers; power-up bit only gates, never reinitializes
    // only byte lane 0 carries register bits; a write without it is answered
    // but leaves every register and the sequencer alone
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= ADCRC_CTRL_RST;
            sc_q <= ADCRC_SC_RST;
            pe_q <= ADCRC_PE_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= wdata_q[7:0];
            end
            if (wr_sc) begin
                sc_q <= wdata_q[7:0];
            end
            if (wr_pe) begin
                pe_q <= wdata_q[7:0];
            end
        end
    end

    // ==========================================================
    // conversion sequencer
    // idle: waits for a status/control write while powered up
    // conv: counts the conversion time; any other register write abandons it,
    //       and so does losing power
    // done: one cycle in which the result moves over and the flag is set
    // a status/control write during conv restarts the count in place, so the
    // old conversion never reaches done and never sets the flag
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ADCRC_IDLE;
            cnt_q <= 6'h00;
            sar_q <= ADCRC_SAR_RST;
        end else begin
            case (state_q)
                ADCRC_IDLE: begin
                    // a write while powered down starts nothing
                    if (wr_sc && ctrl_q[ADCRC_PU_BIT]) begin
                        state_q <= ADCRC_CONV;
                        cnt_q <= 6'h00;
                    end
                end
                ADCRC_CONV: begin
                    if (wr_sc && ctrl_q[ADCRC_PU_BIT]) begin
                        cnt_q <= 6'h00;
                    // any other register write, or power removed, abandons it
                    end else if (wr_ctrl || wr_pe || wr_sc || !ctrl_q[ADCRC_PU_BIT]) begin
                        state_q <= ADCRC_IDLE;
                    // last cycle: capture the analog value
                    end else if (cnt_q == 6'(CONV_CYCLES - 1)) begin
                        state_q <= ADCRC_DONE;
                        sar_q <= sar_sample;
                    end else begin
                        cnt_q <= cnt_q + 6'h01;
                    end
                end
                ADCRC_DONE: begin
                    // flag and result are updated from this state
                    state_q <= ADCRC_IDLE;
                end
                default: begin
                    state_q <= ADCRC_IDLE;
                end
            endcase
        end
    end

    // result moves from sar to result register on completion
    // the result register only changes in done, so software reading it while a
    // new conversion runs sees the previous complete value
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            result_q <= ADCRC_SAR_RST;
        end else if (state_q == ADCRC_DONE) begin
            result_q <= sar_q;
        end
    end

    // ==========================================================
    // done flag: completion set wins over any clear in the same cycle
    // a clear that coincides with completion is lost on purpose: dropping the
    // set would hide a finished conversion from polling software
    logic rd_result;
    assign rd_result = rd_fire && (hit(araddr_q, ADCRC_RH_OFS) || hit(araddr_q, ADCRC_RL_OFS));

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ccf_q <= 1'b0;
        end else if (state_q == ADCRC_DONE) begin
            ccf_q <= 1'b1;
        end else if (wr_sc || rd_result) begin
            ccf_q <= 1'b0;
        end
    end

    // ==========================================================
    // read channel, one cycle of decode then data
    // reading a result register clears the done flag in the cycle the data is
    // latched, so software always gets the value that belonged to the flag
    assign rd_fire = ar_held_q && !s_axi_rvalid;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ar_held_q <= 1'b0;
            araddr_q <= 8'h00;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !ar_held_q && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                ar_held_q <= 1'b1;
                araddr_q <= s_axi_araddr;
            end else if (rd_fire) begin
                ar_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ADCRC_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= ADCRC_RESP_OKAY;
            // unused upper bits read as zero, unmapped offsets as slverr
            if (hit(araddr_q, ADCRC_CTRL_OFS)) begin
                s_axi_rdata <= {24'h000000, ctrl_q};
            end else if (hit(araddr_q, ADCRC_SC_OFS)) begin
                s_axi_rdata <= {24'h000000, ccf_q, sc_q[6:0]};
            end else if (hit(araddr_q, ADCRC_RH_OFS)) begin
                s_axi_rdata <= {30'h0000_0000, result_q[9:8]};
            end else if (hit(araddr_q, ADCRC_RL_OFS)) begin
                s_axi_rdata <= {24'h000000, result_q[7:0]};
            end else if (hit(araddr_q, ADCRC_PE_OFS)) begin
                s_axi_rdata <= {24'h000000, pe_q};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= ADCRC_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // registered outputs
    // interrupt request: follows the done flag while enabled, and drops in the
    // same cycle as a clearing access so it never outlives the flag
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= sc_q[ADCRC_IE_BIT] && (ccf_q || state_q == ADCRC_DONE) &&
                   !((wr_sc || rd_result) && state_q != ADCRC_DONE);
        end
    end

    // power-up level to the analog side, one cycle behind the control bit;
    // the sequencer itself reads the control bit directly
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            converter_power_up <= 1'b0;
        end else begin
            converter_power_up <= ctrl_q[ADCRC_PU_BIT];
        end
    end

    // busy level, one cycle behind the sequencer state
    // it is still high during the done cycle and low from the cycle after
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_busy <= 1'b0;
        end else begin
            conv_busy <= (state_q == ADCRC_CONV);
        end
    end

    // channel select to the input multiplexer
    // it may change during a conversion; the value sampled at the end counts
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            channel_sel <= 3'h0;
        end else begin
            channel_sel <= sc_q[ADCRC_CH_LSB +: 3];
        end
    end

    // pin enables to the input pads
    // copied straight from the pin-enable register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_enable <= 8'h00;
        end else begin
            pin_enable <= pe_q;
        end
    end
endmodule : adcrc_top

// file: bench/adcrc_top_assertions.sv
`timescale 1ns/1ps
module adcrc_top_assertions (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic converter_power_up,
    input wire logic conv_busy,
    input wire logic irq
);
    import adcrc_pkg::*;
    // ==========================================================
    // write and read events seen on the bus
    wire wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire rd_res = s_axi_arvalid && s_axi_arready && (s_axi_araddr == ADCRC_RH_OFS || s_axi_araddr == ADCRC_RL_OFS);
    wire quiet = !s_axi_awvalid && !s_axi_arvalid;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_reset_quiet: assert property ($rose(rst_n) |-> !irq && !conv_busy && !converter_power_up)
        else $error("outputs not cleared after reset");
    a_power_by_write: assert property ($rose(converter_power_up) |-> $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3))
        else $error("power-up rose without a write");
    a_irq_from_conv: assert property ($rose(irq) |-> $past(conv_busy) || $past(conv_busy, 2) || $past(conv_busy, 3))
        else $error("irq rose without a conversion");
    a_irq_holds: assert property (irq && quiet && $past(quiet) && $past(quiet, 2) && $past(quiet, 3) |=> irq)
        else $error("irq dropped without a clearing access");
    a_sc_clears: assert property (wr_hs && s_axi_awaddr == ADCRC_SC_OFS && irq && !conv_busy |-> ##[1:5] !irq)
        else $error("status write left the flag set");
    a_read_clears: assert property (rd_res && irq && !conv_busy |-> ##[1:5] !irq)
        else $error("result read left the flag set");
    a_sc_starts: assert property (wr_hs && s_axi_awaddr == ADCRC_SC_OFS && converter_power_up |-> ##[1:4] conv_busy)
        else $error("status write started no conversion");
    a_start_powered: assert property ($rose(conv_busy) |-> converter_power_up)
        else $error("conversion while powered down");
    a_write_aborts: assert property (wr_hs && conv_busy && (s_axi_awaddr == ADCRC_CTRL_OFS
        || s_axi_awaddr == ADCRC_PE_OFS) |-> ##[1:5] !conv_busy)
        else $error("control or pin write did not abort");
    a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response withdrawn");
    a_rvalid_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read response withdrawn");
    c_irq_rise: cover property ($rose(irq));
    c_abort: cover property (wr_hs && conv_busy && s_axi_awaddr == ADCRC_PE_OFS);
    c_read_clear: cover property (rd_res && irq);
endmodule : adcrc_top_assertions

bind adcrc_top adcrc_top_assertions i_adcrc_top_assertions (.ref_clk(ref_clk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .converter_power_up(converter_power_up), .conv_busy(conv_busy), .irq(irq));

// file: bench/adcrc_analog_model.sv
`timescale 1ns/1ps
module adcrc_analog_model (
    input wire logic ref_clk,
    input wire logic converter_power_up,
    input wire logic [2:0] channel_sel,
    input wire logic [7:0] pin_enable,
    output logic [9:0] sar_sample
);
    logic [9:0] noise_q = 10'h155;
    // ==========================================================
    // front end: level follows channel and pins, toggles when unpowered
    always @(posedge ref_clk) begin
        noise_q <= ~noise_q;
    end
    assign sar_sample = converter_power_up ? {channel_sel, pin_enable[6:0]} : noise_q;
endmodule : adcrc_analog_model

// file: bench/adcrc_top_test.sv
`timescale 1ns/1ps
module adcrc_top_test;
    import adcrc_pkg::*;
    logic ref_clk = 1'h0, rst_n = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pin_enable;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_val;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, converter_power_up, conv_busy, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [9:0] sar_sample;
    logic [2:0] channel_sel;
    int fail_count = 0;
    int n_checks = 0;
    int i;
    adcrc_top #(.CONV_CYCLES(10)) i_adcrc_top (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .sar_sample(sar_sample), .converter_power_up(converter_power_up),
        .conv_busy(conv_busy), .channel_sel(channel_sel), .pin_enable(pin_enable), .irq(irq));
    adcrc_analog_model i_adcrc_analog_model (.ref_clk(ref_clk), .converter_power_up(converter_power_up),
        .channel_sel(channel_sel), .pin_enable(pin_enable), .sar_sample(sar_sample));
    // ==========================================================
    // clock, verdict and helpers
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic final_report();
        if (fail_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one bus transfer: write when wr is high, read otherwise
    task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int k;
        @(posedge ref_clk);
        s_axi_awaddr <= addr;
        s_axi_araddr <= addr;
        s_axi_wdata <= data;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_bready <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready <= !wr;
        for (k = 0; k < 40; k++) begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if ((wr && s_axi_bvalid) || (!wr && s_axi_rvalid)) break;
        end
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
        resp = wr ? s_axi_bresp : s_axi_rresp;
        rd_val = s_axi_rdata;
        if (k == 40) begin
            fail_count++;
            final_report();
        end
    endtask : bus
    task automatic wait_irq(input logic want);
        int k;
        for (k = 0; k < 60 && irq !== want; k++) @(posedge ref_clk);
        if (k == 60) begin
            fail_count++;
            final_report();
        end
    endtask : wait_irq
    task automatic poll_done();
        rd_val = 32'h0;
        for (int p = 0; p < 20 && rd_val[7] !== 1'h1; p++) begin
            bus(1'h0, ADCRC_SC_OFS, 32'h0);
        end
        check("polled status", rd_val, 32'h85);
        check("irq disabled", 32'(irq), 32'h0);
    endtask : poll_done
    task automatic pulse_reset();
        @(posedge ref_clk);
        rst_n <= 1'h0;
        repeat (3) @(posedge ref_clk);
        check("irq in reset", 32'(irq), 32'h0);
        check("busy in reset", 32'(conv_busy), 32'h0);
        check("power in reset", 32'(converter_power_up), 32'h0);
        rst_n <= 1'h1;
    endtask : pulse_reset
    // ==========================================================
    // main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'h1;
        for (i = 0; i < 5; i++) begin
            bus(1'h0, 8'(i * 4), 32'h0);
            check("reset value", rd_val, 32'h0);
        end
        bus(1'h0, 8'h18, 32'h0);
        check("unmapped read", 32'(resp), 32'(ADCRC_RESP_SLVERR));
        bus(1'h1, 8'h18, 32'h1);
        check("unmapped write", 32'(resp), 32'(ADCRC_RESP_SLVERR));
        bus(1'h1, ADCRC_PE_OFS, 32'h5a);
        bus(1'h1, ADCRC_CTRL_OFS, 32'h80);
        bus(1'h0, ADCRC_PE_OFS, 32'h0);
        check("pins after power-up", rd_val, 32'h5a);
        check("pin enable out", 32'(pin_enable), 32'h5a);
        bus(1'h1, ADCRC_SC_OFS, 32'h43);
        wait_irq(1'h1);
        check("channel out", 32'(channel_sel), 32'h3);
        repeat (5) @(posedge ref_clk);
        check("irq held", 32'(irq), 32'h1);
        bus(1'h0, ADCRC_SC_OFS, 32'h0);
        check("status done", rd_val, 32'hc3);
        bus(1'h0, ADCRC_RL_OFS, 32'h0);
        check("result low", rd_val, 32'hda);
        wait_irq(1'h0);
        bus(1'h0, ADCRC_SC_OFS, 32'h0);
        check("flag after low read", rd_val, 32'h43);
        bus(1'h1, ADCRC_SC_OFS, 32'h05);
        poll_done();
        bus(1'h1, ADCRC_SC_OFS, 32'h05);
        bus(1'h0, ADCRC_SC_OFS, 32'h0);
        check("flag after status write", rd_val, 32'h05);
        poll_done();
        bus(1'h0, ADCRC_RH_OFS, 32'h0);
        check("result high", rd_val, 32'h2);
        bus(1'h0, ADCRC_SC_OFS, 32'h0);
        check("flag after high read", rd_val, 32'h05);
        for (i = 0; i < 2; i++) begin
            bus(1'h1, ADCRC_SC_OFS, 32'h41);
            bus(1'h1, i ? ADCRC_PE_OFS : ADCRC_CTRL_OFS, i ? 32'h5a : 32'h80);
            repeat (30) @(posedge ref_clk);
            check("busy after abort", 32'(conv_busy), 32'h0);
            bus(1'h0, ADCRC_SC_OFS, 32'h0);
            check("no completion after abort", rd_val, 32'h41);
        end
        bus(1'h1, ADCRC_SC_OFS, 32'h41);
        repeat (6) @(posedge ref_clk);
        bus(1'h1, ADCRC_SC_OFS, 32'h41);
        repeat (3) @(posedge ref_clk);
        check("first conversion aborted", 32'(irq), 32'h0);
        wait_irq(1'h1);
        pulse_reset();
        bus(1'h1, ADCRC_CTRL_OFS, 32'h80);
        bus(1'h1, ADCRC_SC_OFS, 32'h41);
        pulse_reset();
        bus(1'h0, ADCRC_SC_OFS, 32'h0);
        check("status after reset", rd_val, 32'h0);
        bus(1'h0, ADCRC_RL_OFS, 32'h0);
        check("result after reset", rd_val, 32'h0);
        final_report();
    end
endmodule : adcrc_top_test
